// [src/i2cst_map.svh]
// Register offsets, field positions, reset values and timing constants of the I2C slave.
`ifndef I2CST_MAP_SVH
`define I2CST_MAP_SVH
// ****************************************
// Register offsets on the plain port
// ****************************************
`define I2CST_OFF_DATA 3'h0
`define I2CST_OFF_ADDR 3'h1
`define I2CST_OFF_CTRL0 3'h2
`define I2CST_OFF_BSC 3'h3
`define I2CST_OFF_TOC 3'h4
// ****************************************
// Field positions
// ****************************************
`define I2CST_BSC_DONE 7
`define I2CST_BSC_MATCH 6
`define I2CST_BSC_BUSY 5
`define I2CST_BSC_TX 4
`define I2CST_BSC_ACKO 3
`define I2CST_BSC_DIR 2
`define I2CST_BSC_WAKE 1
`define I2CST_BSC_ACKI 0
`define I2CST_TOC_EN 7
`define I2CST_TOC_FLAG 6
`define I2CST_CTRL0_EN 1
`define I2CST_CTRL0_MODE 7:5
`define I2CST_ADDR_FIELD 7:1
`define I2CST_TOC_SEL 5:0
`define I2CST_MODE_I2C 3'h6
// ****************************************
// Reset values
// ****************************************
`define I2CST_BSC_POR 8'h81
`define I2CST_TOC_POR 8'h00
`define I2CST_BYTE_POR 8'h00
// ****************************************
// Counts and timing
// ****************************************
`define I2CST_BIT_LAST 4'h7
`define I2CST_BIT_ACK 4'h8
`define I2CST_CLK_HZ 20000000
`define I2CST_SUB_HZ 32768
`define I2CST_SUB_DIV (`I2CST_CLK_HZ / `I2CST_SUB_HZ)
`define I2CST_SUB_LAST 10'(`I2CST_SUB_DIV - 1)
`define I2CST_PRE_LAST 5'h1f
`endif

// [src/i2cst_pkg.sv]
// Types shared by the I2C slave design.
package i2cst_pkg;
	// Protocol states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_DATA = 6'h04,
		ST_ACK = 6'h08,
		ST_IGNORE = 6'h10,
		ST_SPARE = 6'h20
	} i2cst_state_t;
endpackage

// [src/i2cst_slave.sv]
// I2C slave interface with SCL stretching, status flags and bus time-out.
//
// Functional notes
// - Shift seven address bits MSB first, compare.
// - Address match sets flag, raises interrupt.
// - Eighth bit after START is direction.
// - Direction one means slave transmits.
// - START is SDA fall, SCL high; busy.
// - Only master makes START; slave never.
// - Matched address is acknowledged by slave.
// - Transmit-select bit picks transmitter or receiver.
// - Data bytes eight bits, MSB first.
// - Receiver drives low acknowledge per byte.
// - Receiver drives ack control on ninth clock.
// - Transmitter releases SDA on missing acknowledge.
// - One data register for both directions.
// - Hold SCL low until software services.
// - One interrupt: match, byte done, time-out.
// - Time-out counts from match, cleared SCL fall.
// - Time-out when period passes without fall.
// - STOP halts time-out counting.
// - Overflow stops, disables, flags, interrupts, resets.
// - Time-out resets only bus status/control register.
// - Software clears time-out flag by writing.
// - Period is selection plus one, times 32.
// - Runs when mode 110 and enabled.
// - Done flag low while moving, high after.
// - STOP clears the busy flag.
// - Selection in bits 5..0, sub-clock over 32.
`timescale 1ns/1ps
`include "i2cst_map.svh"
module i2cst_slave
	import i2cst_pkg::*;
(
	input wire logic clk, // System clock, 20 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [2:0] addr, // Register index.
	input wire logic [7:0] wdata, // Write data.
	input wire logic wr_en, // Write strobe.
	input wire logic rd_en, // Read strobe.
	output logic [7:0] rdata, // Read data, one cycle after the strobe.
	output logic bus_irq, // One-cycle bus interrupt pulse.
	input wire logic scl_i, // SCL pin level.
	output logic scl_o, // SCL output value, always low.
	output logic scl_oe, // SCL drive enable, high holds SCL low.
	input wire logic sda_i, // SDA pin level.
	output logic sda_o, // SDA output value, always low.
	output logic sda_oe // SDA drive enable, high pulls SDA low.
);
	// ****************************************
	// Declarations
	// ****************************************
	logic scl_s1_reg, scl_s2_reg, scl_d_reg; // SCL synchroniser and history.
	logic sda_s1_reg, sda_s2_reg, sda_d_reg; // SDA synchroniser and history.
	i2cst_state_t state_reg; // Protocol state.
	logic [3:0] bitcnt_reg; // SCL rises seen in the current byte.
	logic [7:0] shift_reg; // Serial shifter.
	logic is_addr_reg; // Current byte is the address byte.
	logic stretch_reg; // SCL is being held low.
	logic [7:0] data_reg; // Shared data register.
	logic [7:0] own_addr_reg; // Own address in bits 7..1.
	logic [7:0] ctrl0_reg; // Mode field 7..5 and enable bit.
	logic done_reg, match_reg, busy_reg, dir_reg, acki_reg; // Status flags.
	logic tx_reg, acko_reg, wake_reg; // Software control bits.
	logic to_en_reg, to_flag_reg; // Time-out enable and flag.
	logic [5:0] to_sel_reg; // Time-out period selection.
	logic [9:0] sub_cnt_reg; // Divider down to the sub-clock rate.
	logic [4:0] pre_cnt_reg; // Sub-clock divide by 32.
	logic [5:0] to_cnt_reg; // Time-out ticks since the last SCL fall.
	logic to_run_reg; // Time-out counter is running.
	logic irq_reg, sda_oe_reg, scl_oe_reg; // Output flops.
	logic [7:0] rdata_reg; // Read data flop.
	localparam logic [7:0] BSC_POR = `I2CST_BSC_POR; // Status/control power-on value, one bit per flag.
	// ****************************************
	// Decoding
	// ****************************************
	wire active = ctrl0_reg[`I2CST_CTRL0_EN] & (ctrl0_reg[`I2CST_CTRL0_MODE] == `I2CST_MODE_I2C); // Module in I2C mode.
	wire scl_rise = scl_s2_reg & ~scl_d_reg; // SCL rising edge.
	wire scl_fall = ~scl_s2_reg & scl_d_reg; // SCL falling edge.
	wire start_det = active & scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg; // SDA falls, SCL high.
	wire stop_det = active & scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg; // SDA rises, SCL high.
	wire in_addr = (state_reg == ST_ADDR); // Address phase.
	wire in_data = (state_reg == ST_DATA); // Data phase.
	wire in_ack = (state_reg == ST_ACK); // Ninth clock.
	wire last_rise = scl_rise & (bitcnt_reg == `I2CST_BIT_LAST); // Eighth rise of a byte.
	wire addr_done = in_addr & last_rise; // Whole address byte seen.
	wire addr_eq = (shift_reg[6:0] == own_addr_reg[`I2CST_ADDR_FIELD]); // Calling address equals own address.
	wire match_hit = addr_done & addr_eq; // Address matched.
	wire byte_rx = in_data & ~tx_reg & last_rise; // Received byte complete.
	wire ack_rise = in_ack & ~is_addr_reg & scl_rise; // Ninth clock rising after a data byte.
	wire ack_end = in_ack & scl_fall; // Ninth clock over.
	wire byte_end = (bitcnt_reg == `I2CST_BIT_ACK) & scl_fall; // Fall after the eighth bit.
	wire wr_data = wr_en & (addr == `I2CST_OFF_DATA); // Data register write.
	wire rd_data = rd_en & (addr == `I2CST_OFF_DATA); // Data register read.
	wire wr_bsc = wr_en & (addr == `I2CST_OFF_BSC); // Status/control write.
	wire wr_toc = wr_en & (addr == `I2CST_OFF_TOC); // Time-out control write.
	wire sw_release = stretch_reg & ((wr_data & tx_reg) | (rd_data & ~tx_reg)); // Service done.
	wire sub_tick = (sub_cnt_reg == `I2CST_SUB_LAST); // One pulse per sub-clock period.
	wire to_tick = sub_tick & (pre_cnt_reg == `I2CST_PRE_LAST); // Sub-clock divided by 32.
	wire to_hit = to_run_reg & to_tick & (to_cnt_reg == to_sel_reg); // Selection plus one ticks passed.
	wire bus_reset = to_hit | ~active; // Return the bus logic to idle.
	wire [7:0] bsc_rd = {done_reg, match_reg, busy_reg, tx_reg, acko_reg, dir_reg, wake_reg, acki_reg}; // Status.
	wire [7:0] toc_rd = {to_en_reg, to_flag_reg, to_sel_reg}; // Time-out control readback.
	wire ack_drive = in_ack & (is_addr_reg | (~tx_reg & ~acko_reg)); // Slave acknowledge on ninth clock.
	wire tx_drive = in_data & tx_reg & ~stretch_reg & ~shift_reg[7]; // Current bit is zero.
	// only pull-low of SDA, never a START
	wire sda_next = (ack_drive | tx_drive) & active; // SDA pull-down request.
	wire [7:0] rd_mux; // Selected read value.
	// Read selection, unmapped offsets answer zero.
	assign rd_mux = (addr == `I2CST_OFF_DATA) ? data_reg :
		(addr == `I2CST_OFF_ADDR) ? own_addr_reg :
		(addr == `I2CST_OFF_CTRL0) ? ctrl0_reg :
		(addr == `I2CST_OFF_BSC) ? bsc_rd :
		(addr == `I2CST_OFF_TOC) ? toc_rd : `I2CST_BYTE_POR;
	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Two flops per pin, then one history flop for edge detection.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_s1_reg <= scl_i;
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg <= scl_s2_reg;
			sda_s1_reg <= sda_i;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg <= sda_s2_reg;
		end
	end
	// ****************************************
	// Protocol state machine
	// ****************************************
	// Tracks START, address, data bits, ninth clock and SCL hold.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			bitcnt_reg <= 4'h0;
			shift_reg <= `I2CST_BYTE_POR;
			is_addr_reg <= 1'b0;
			stretch_reg <= 1'b0;
		end else if (bus_reset) begin
			state_reg <= ST_IDLE;
			stretch_reg <= 1'b0;
			bitcnt_reg <= 4'h0;
		end else if (start_det) begin
			state_reg <= ST_ADDR;
			bitcnt_reg <= 4'h0;
			is_addr_reg <= 1'b1;
			stretch_reg <= 1'b0;
		end else if (stop_det) begin
			state_reg <= ST_IDLE;
			stretch_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_ADDR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s2_reg};
						bitcnt_reg <= bitcnt_reg + 4'h1;
						// Not our address: ignore until the next START.
						if (addr_done && !addr_eq) begin
							state_reg <= ST_IGNORE;
						end
					end else if (byte_end) begin
						state_reg <= ST_ACK;
					end
				end
				ST_DATA: begin
					if (sw_release) begin
						stretch_reg <= 1'b0;
						if (tx_reg) begin
							shift_reg <= wdata;
						end
					end else if (scl_rise) begin
						bitcnt_reg <= bitcnt_reg + 4'h1;
						if (!tx_reg) begin
							shift_reg <= {shift_reg[6:0], sda_s2_reg};
						end
					end else if (byte_end) begin
						state_reg <= ST_ACK;
					end else if (scl_fall && tx_reg && !stretch_reg) begin
						// Next bit onto SDA after each low-going edge.
						shift_reg <= {shift_reg[6:0], 1'b0};
					end
				end
				ST_ACK: begin
					if (ack_end) begin
						bitcnt_reg <= 4'h0;
						is_addr_reg <= 1'b0;
						// master refused, release and wait for STOP
						if (!is_addr_reg && tx_reg && acki_reg) begin
							state_reg <= ST_IGNORE;
						end else begin
							state_reg <= ST_DATA;
							stretch_reg <= 1'b1;
						end
					end
				end
				default: begin
					state_reg <= state_reg;
				end
			endcase
		end
	end
	// ****************************************
	// Status flags and control bits
	// ****************************************
	// Hardware events update the flags; software writes the control bits.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{done_reg, match_reg, busy_reg, tx_reg, acko_reg, dir_reg, wake_reg, acki_reg} <= `I2CST_BSC_POR;
		end else if (to_hit) begin
			done_reg <= BSC_POR[`I2CST_BSC_DONE];
			match_reg <= BSC_POR[`I2CST_BSC_MATCH];
			busy_reg <= BSC_POR[`I2CST_BSC_BUSY];
			tx_reg <= BSC_POR[`I2CST_BSC_TX];
			acko_reg <= BSC_POR[`I2CST_BSC_ACKO];
			dir_reg <= BSC_POR[`I2CST_BSC_DIR];
			wake_reg <= BSC_POR[`I2CST_BSC_WAKE];
			acki_reg <= BSC_POR[`I2CST_BSC_ACKI];
		end else begin
			// Control bits keep their value while the module is off.
			if (wr_bsc) begin
				tx_reg <= wdata[`I2CST_BSC_TX];
				acko_reg <= wdata[`I2CST_BSC_ACKO];
				wake_reg <= wdata[`I2CST_BSC_WAKE];
			end
			if (!active) begin
				// Flags rest at their defaults while the module is off.
				done_reg <= BSC_POR[`I2CST_BSC_DONE];
				match_reg <= BSC_POR[`I2CST_BSC_MATCH];
				busy_reg <= BSC_POR[`I2CST_BSC_BUSY];
				dir_reg <= BSC_POR[`I2CST_BSC_DIR];
				acki_reg <= BSC_POR[`I2CST_BSC_ACKI];
			end else if (start_det) begin
				busy_reg <= 1'b1;
				match_reg <= 1'b0;
				done_reg <= 1'b0;
			end else if (stop_det) begin
				busy_reg <= 1'b0;
				match_reg <= 1'b0;
			end else if (match_hit) begin
				match_reg <= 1'b1;
				dir_reg <= sda_s2_reg;
				done_reg <= 1'b1;
			end else if (ack_rise) begin
				done_reg <= 1'b1;
				match_reg <= 1'b0;
				if (tx_reg) begin
					acki_reg <= sda_s2_reg;
				end
			end else if (sw_release) begin
				done_reg <= 1'b0;
			end
		end
	end
	// ****************************************
	// Software registers
	// ****************************************
	// Data, own address and mode; a time-out leaves them alone.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_reg <= `I2CST_BYTE_POR;
			own_addr_reg <= `I2CST_BYTE_POR;
			ctrl0_reg <= `I2CST_BYTE_POR;
		end else begin
			// received byte lands in the data register
			if (byte_rx) begin
				data_reg <= {shift_reg[6:0], sda_s2_reg};
			end else if (wr_data) begin
				data_reg <= wdata;
			end
			if (wr_en && addr == `I2CST_OFF_ADDR) begin
				own_addr_reg <= wdata;
			end
			if (wr_en && addr == `I2CST_OFF_CTRL0) begin
				ctrl0_reg <= wdata;
			end
		end
	end
	// ****************************************
	// Time-out
	// ****************************************
	// Free-running sub-clock divider and divide by 32.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sub_cnt_reg <= 10'h000;
			pre_cnt_reg <= 5'h00;
		end else begin
			sub_cnt_reg <= sub_tick ? 10'h000 : sub_cnt_reg + 10'h001;
			// time-out clock is sub-clock over 32
			if (sub_tick) begin
				pre_cnt_reg <= pre_cnt_reg + 5'h01;
			end
		end
	end
	// Counts time-out ticks between SCL falls after a match.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			to_run_reg <= 1'b0;
			to_cnt_reg <= 6'h00;
		end else if (to_hit || stop_det || !active) begin
			to_run_reg <= 1'b0;
			to_cnt_reg <= 6'h00;
		end else if (match_hit) begin
			to_run_reg <= to_en_reg;
			to_cnt_reg <= 6'h00;
		end else if (scl_fall) begin
			to_cnt_reg <= 6'h00;
		end else if (to_run_reg && to_tick) begin
			to_cnt_reg <= to_cnt_reg + 6'h01;
		end
	end
	// Time-out control register; hardware set wins over software clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{to_en_reg, to_flag_reg, to_sel_reg} <= `I2CST_TOC_POR;
		end else begin
			if (wr_toc) begin
				to_sel_reg <= wdata[`I2CST_TOC_SEL];
			end
			if (to_hit) begin
				to_en_reg <= 1'b0;
				to_flag_reg <= 1'b1;
			end else if (wr_toc) begin
				to_en_reg <= wdata[`I2CST_TOC_EN];
				to_flag_reg <= wdata[`I2CST_TOC_FLAG];
			end
		end
	end
	// ****************************************
	// Outputs
	// ****************************************
	// Drive enables, interrupt and read data come from flops; pins only ever pull low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			rdata_reg <= `I2CST_BYTE_POR;
		end else begin
			irq_reg <= match_hit | ack_rise | to_hit;
			sda_oe_reg <= sda_next;
			scl_oe_reg <= stretch_reg & ~bus_reset;
			rdata_reg <= rd_en ? rd_mux : `I2CST_BYTE_POR;
		end
	end
	assign rdata = rdata_reg;
	assign bus_irq = irq_reg;
	assign sda_oe = sda_oe_reg;
	assign scl_oe = scl_oe_reg;
	assign sda_o = 1'b0;
	assign scl_o = 1'b0;
endmodule

// [test/i2cst_master.sv]
// Behavioural I2C bus master for the bench.
`timescale 1ns/1ps
module i2cst_master (
	input wire logic clk, // Pacing clock.
	input wire logic scl, // SCL wire.
	input wire logic sda, // SDA wire.
	output logic scl_low, // Pulls SCL low.
	output logic sda_low, // Pulls SDA low.
	output logic hang // SCL held low too long.
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		hang = 1'b0;
	end
	// One quarter of an SCL period.
	task automatic qw();
		repeat (8) @(posedge clk);
	endtask
	// Releases SCL and waits, bounded, while the slave stretches it.
	task automatic rise();
		int n;
		n = 0;
		scl_low <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (scl !== 1'b1 && n < 2000);
		hang = hang | (n >= 2000);
		qw();
	endtask
	task automatic fall();
		scl_low <= 1'b1;
		qw();
	endtask
	task automatic put(input logic b);
		sda_low <= ~b;
		qw();
		rise();
		qw();
		fall();
	endtask
	// Samples SDA in the middle of SCL high.
	task automatic get(output logic b);
		sda_low <= 1'b0;
		qw();
		rise();
		b = sda;
		qw();
		fall();
	endtask
	task automatic start();
		sda_low <= 1'b0;
		qw();
		rise();
		sda_low <= 1'b1;
		qw();
		fall();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		qw();
		rise();
		sda_low <= 1'b0;
		qw();
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) put(d[i]);
		get(ack);
	endtask
	task automatic recv(input logic nack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get(d[i]);
		put(nack);
	endtask
endmodule

// [test/i2cst_monitor.sv]
// Checker of the I2C slave ports.
`timescale 1ns/1ps
module i2cst_monitor (
	input wire logic clk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic [2:0] addr, // Index.
	input wire logic [7:0] wdata, // Write data.
	input wire logic wr_en, // Write strobe.
	input wire logic rd_en, // Read strobe.
	input wire logic [7:0] rdata, // Read data.
	input wire logic bus_irq, // Interrupt.
	input wire logic scl_i, // SCL wire.
	input wire logic scl_o, // SCL value.
	input wire logic scl_oe, // SCL pull.
	input wire logic sda_i, // SDA wire.
	input wire logic sda_o, // SDA value.
	input wire logic sda_oe // SDA pull.
);
	logic scl_q, sda_q, byte0, in_frame; // Pin history and frame state.
	logic [3:0] pos; // SCL rises within the current byte.
	logic [3:0] quiet_cnt; // Cycles since the bus went free, saturating.
	wire start_seen = scl_q && scl_i && sda_q && !sda_i;
	wire stop_seen = scl_q && scl_i && !sda_q && sda_i;
	wire scl_rise = !scl_q && scl_i;
	wire scl_fall = scl_q && !scl_i;
	// Tracks bit slots so drive changes can be tied to their clock.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			pos <= 4'h0;
			byte0 <= 1'b0;
			in_frame <= 1'b0;
			quiet_cnt <= 4'h0;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			pos <= start_seen ? 4'h0 : (scl_rise ? ((pos == 4'h9) ? 4'h1 : pos + 4'h1) : pos);
			// The address byte lasts until the low-going edge after its ninth clock.
			byte0 <= start_seen || (byte0 && !(scl_fall && pos == 4'h9));
			in_frame <= start_seen || (in_frame && !stop_seen);
			quiet_cnt <= in_frame ? 4'h0 : ((quiet_cnt == 4'hf) ? quiet_cnt : quiet_cnt + 4'h1);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("SDA drive moved while SCL high");
	AST_OPEN_DRAIN: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("pin value not low");
	AST_IRQ_PULSE: assert property (bus_irq |=> !bus_irq)
		else $error("interrupt longer than one cycle");
	AST_RDATA_QUIET: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("read data without read");
	AST_STRETCH_SLOT: assert property ($rose(scl_oe) |-> pos == 4'h9 && !scl_i)
		else $error("stretch outside ninth clock");
	AST_ADDR_ACK_SLOT: assert property ($rose(sda_oe) && byte0 |-> pos == 4'h8)
		else $error("address byte driven before ack slot");
	AST_ACK_END: assert property ($fell(byte0) && sda_oe |-> ##[1:8] !sda_oe)
		else $error("address ack not released after ninth clock");
	AST_IDLE_QUIET: assert property (quiet_cnt > 4'h6 |-> !sda_oe && !scl_oe)
		else $error("bus driven while free");
endmodule
bind i2cst_slave i2cst_monitor mon_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .bus_irq(bus_irq), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// [test/tb_i2c_slave_with_timeout.sv]
// Bench for the I2C slave: registers, transfers and time-out.
`timescale 1ns/1ps
`include "i2cst_map.svh"
module tb_i2c_slave_with_timeout;
	logic clk, rst_n, wr_en, rd_en, bus_irq, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, hang, ack;
	logic [2:0] addr;
	logic [6:0] own;
	logic [7:0] wdata, rdata, rv, d;
	int n_mismatch = 0, samples_checked = 0, irqs = 0, n, t;
	// Open-drain wires with pull-ups.
	wire scl_w = ~m_scl & (scl_oe ? scl_o : 1'b1);
	wire sda_w = ~m_sda & (sda_oe ? sda_o : 1'b1);
	i2cst_slave dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .bus_irq(bus_irq), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe));
	i2cst_master m_u (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda), .hang(hang));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (bus_irq === 1'b1) irqs++;
	end
	task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", w, e, s);
		end
	endtask
	// Clock cycles in (sel + 1) time-out ticks of the sub-clock divided by 32.
	function automatic int to_cycles(input int sel);
		return (sel + 1) * 32 * (`I2CST_CLK_HZ / `I2CST_SUB_HZ);
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		v = rdata;
	endtask
	task automatic rc(input string w, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(w, v & m, e);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog sized above the two long time-out waits.
	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
	initial begin
		{rst_n, wr_en, rd_en, addr, wdata} = '0;
		void'($urandom(99));
		own = 7'($urandom_range(8, 119));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc("status", `I2CST_OFF_BSC, 8'hff, 8'h81);
		rc("timeout", `I2CST_OFF_TOC, 8'hff, 8'h00);
		rc("unmapped", 3'h5, 8'hff, 8'h00);
		wr(`I2CST_OFF_BSC, 8'hff);
		rc("status rw", `I2CST_OFF_BSC, 8'hff, 8'h9b);
		wr(`I2CST_OFF_BSC, 8'h00);
		wr(`I2CST_OFF_ADDR, {own, 1'b0});
		$display("test registers done");
		// Enable off, then wrong mode: calls go unanswered, master then stops.
		for (int k = 0; k < 2; k++) begin
			wr(`I2CST_OFF_CTRL0, (k == 0) ? 8'hc0 : 8'ha2);
			m_u.start();
			m_u.send({own, 1'b0}, ack);
			chk("ack off", 8'(ack), 8'h01);
			m_u.stop();
		end
		wr(`I2CST_OFF_CTRL0, 8'hc2);
		wr(`I2CST_OFF_TOC, 8'hbf);
		n = irqs;
		m_u.start();
		m_u.send({own, 1'b0}, ack);
		chk("addr ack", 8'(ack), 8'h00);
		rc("match", `I2CST_OFF_BSC, 8'he4, 8'he0);
		chk("match irq", 8'(irqs - n), 8'h01);
		chk("stretch", 8'(scl_oe), 8'h01);
		rd(`I2CST_OFF_DATA, rv);
		repeat (2) @(posedge clk);
		chk("unstretch", 8'(scl_oe), 8'h00);
		rc("moving", `I2CST_OFF_BSC, 8'h80, 8'h00);
		// Four random bytes in, the last one refused by ack control.
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			if (i == 3) wr(`I2CST_OFF_BSC, 8'h08);
			n = irqs;
			m_u.send(d, ack);
			chk("rx ack", 8'(ack), {7'h00, i == 3});
			rc("done", `I2CST_OFF_BSC, 8'h80, 8'h80);
			chk("byte irq", 8'(irqs - n), 8'h01);
			rc("rx data", `I2CST_OFF_DATA, 8'hff, d);
		end
		wr(`I2CST_OFF_BSC, 8'h00);
		m_u.stop();
		rc("free", `I2CST_OFF_BSC, 8'h20, 8'h00);
		$display("test write done");
		m_u.start();
		m_u.send({own, 1'b1}, ack);
		chk("rd ack", 8'(ack), 8'h00);
		rc("dir", `I2CST_OFF_BSC, 8'h04, 8'h04);
		wr(`I2CST_OFF_BSC, 8'h10);
		for (int i = 0; i < 2; i++) begin
			d = 8'($urandom);
			wr(`I2CST_OFF_DATA, d);
			m_u.recv(i == 1, rv);
			chk("tx data", rv, d);
		end
		repeat (4) @(posedge clk);
		chk("nack sda", 8'(sda_oe), 8'h00);
		rc("ack in", `I2CST_OFF_BSC, 8'h01, 8'h01);
		m_u.stop();
		wr(`I2CST_OFF_BSC, 8'h00);
		n = irqs;
		m_u.start();
		m_u.send({own ^ 7'h01, 1'b0}, ack);
		chk("foreign ack", 8'(ack), 8'h01);
		chk("foreign irq", 8'(irqs - n), 8'h00);
		m_u.stop();
		$display("test read done");
		// Two-tick time-out; a STOP must halt it.
		wr(`I2CST_OFF_TOC, 8'h81);
		m_u.start();
		m_u.send({own, 1'b0}, ack);
		rd(`I2CST_OFF_DATA, rv);
		m_u.stop();
		n = irqs;
		repeat (40000) @(posedge clk);
		chk("halted irq", 8'(irqs - n), 8'h00);
		rc("halted", `I2CST_OFF_TOC, 8'hff, 8'h81);
		m_u.start();
		m_u.send({own, 1'b0}, ack);
		n = irqs;
		t = 0;
		while (irqs == n && t < 40000) begin
			@(posedge clk);
			t++;
		end
		chk("to irq", 8'(irqs - n), 8'h01);
		chk("to late", 8'(t >= to_cycles(0) - 16), 8'h01);
		chk("to early", 8'(t <= to_cycles(1) + 16), 8'h01);
		rc("to ctrl", `I2CST_OFF_TOC, 8'hff, 8'h41);
		rc("to status", `I2CST_OFF_BSC, 8'hff, 8'h81);
		rc("to ctrl0", `I2CST_OFF_CTRL0, 8'hff, 8'hc2);
		rc("to addr", `I2CST_OFF_ADDR, 8'hfe, {own, 1'b0});
		chk("to scl", 8'(scl_oe), 8'h00);
		wr(`I2CST_OFF_TOC, 8'h01);
		rc("to clear", `I2CST_OFF_TOC, 8'hff, 8'h01);
		m_u.stop();
		chk("hang", 8'(hang), 8'h00);
		$display("test timeout done");
		stop_test();
	end
endmodule
